// *** hdl/i2csr_line_if.sv ***
// Sampled bus levels and bus events passed from the line sampler to the core.
// Everything here belongs to the system clock domain.
`timescale 1ns/1ps
interface i2csr_line_if;
    logic scl;
    logic sda;
    logic strap;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    modport sampler (
        output scl, sda, strap, scl_rise, scl_fall, start, stop
    );
    modport core (
        input scl, sda, strap, scl_rise, scl_fall, start, stop
    );
endinterface

// *** hdl/i2csr_params.svh ***
// Constants for the serial register access slave.
// Included by every design file that needs a number.
`ifndef I2CSR_PARAMS_SVH
`define I2CSR_PARAMS_SVH

`define I2CSR_ADDR_STRAP_LO 7'h20
`define I2CSR_ADDR_STRAP_HI 7'h21
`define I2CSR_DIR_WRITE 1'h0
`define I2CSR_DIR_READ 1'h1
`define I2CSR_BIT_FIRST 3'h0
`define I2CSR_BIT_LAST 3'h7
`define I2CSR_BYTE_MSB 7
`define I2CSR_BYTE_ZERO 8'h00
`define I2CSR_SDA_LOW 1'h0

`endif

// *** hdl/i2csr_pkg.sv ***
// Types shared by the serial register access slave and its line sampler.
// Assumes it is compiled before every file that names its types.
package i2csr_pkg;

    typedef enum logic [3:0] {
        I2CSR_IDLE = 4'h0,
        I2CSR_ADDR = 4'h1,
        I2CSR_ACK_ADDR = 4'h3,
        I2CSR_REG = 4'h2,
        I2CSR_ACK_REG = 4'h6,
        I2CSR_WDATA = 4'h7,
        I2CSR_ACK_W = 4'h5,
        I2CSR_RDATA = 4'h4,
        I2CSR_RACK = 4'hc,
        I2CSR_IGNORE = 4'hd
    } i2csr_state_t;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic strap_m;
        logic strap_s;
    } i2csr_sync_t;

    typedef struct packed {
        i2csr_state_t state;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic ack_drv;
        logic oe;
        logic sdo;
        logic addr_sel;
        logic [7:0] idx;
        logic [7:0] wdata;
        logic wr;
    } i2csr_core_t;

endpackage

// *** hdl/i2csr_slave.sv ***
// Two-wire serial slave giving a bus master access to a register file.
// Assumes the register file answers reg_rdata_in combinationally for
// reg_index_out, and that a pull-up resolves the data pin from sda_oe_out.
//
// Functional notes
// - Bytes are eight bits, MSB first.
// - One acknowledge slot follows every byte.
// - Transmitter releases data during acknowledge pulse.
// - Receiver holds data low on ninth pulse.
// - Addressed slave acknowledges every received byte.
// - Strap picks address 20h or 21h.
// - Direction bit zero writes, one reads.
// - First write byte selects register index.
// - Next write byte stored into indexed register.
// - START is data falling while clock high.
// - STOP is data rising while clock high.
// - Repeated START restarts address reception.
// - Data changes only while clock low.
`timescale 1ns/1ps
`include "i2csr_params.svh"
module i2csr_slave (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_sel_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_index_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out
);

    i2csr_line_if line ();

    i2csr_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .strap_in(addr_sel_in),
        .line(line.sampler)
    );

    ////////////////////////////////////////////////////////////////////////

    i2csr_pkg::i2csr_core_t st_reg;
    i2csr_pkg::i2csr_core_t st_next;
    logic [7:0] shin;

    function automatic logic addr_match(input logic [6:0] a,
                                        input logic sel);
        addr_match = (a == (sel ? `I2CSR_ADDR_STRAP_HI
                                : `I2CSR_ADDR_STRAP_LO));
    endfunction

    assign shin = {st_reg.sh[6:0], line.sda};

    always_comb begin
        st_next = st_reg;
        st_next.wr = 1'b0;
        st_next.sdo = `I2CSR_SDA_LOW;
        if (line.stop) begin
            st_next.state = i2csr_pkg::I2CSR_IDLE;
            st_next.oe = 1'b0;
        end else if (line.start) begin
            st_next.state = i2csr_pkg::I2CSR_ADDR;
            st_next.cnt = `I2CSR_BIT_FIRST;
            st_next.oe = 1'b0;
            st_next.ack_drv = 1'b0;
        end else begin
            case (st_reg.state)
                i2csr_pkg::I2CSR_IDLE: begin
                    // The strap is followed only while the bus is free, so
                    // a strap change never retargets a running transfer.
                    st_next.addr_sel = line.strap;
                end
                i2csr_pkg::I2CSR_ADDR,
                i2csr_pkg::I2CSR_REG,
                i2csr_pkg::I2CSR_WDATA: begin
                    if (line.scl_rise) begin
                        st_next.sh = shin;
                        st_next.cnt = st_reg.cnt + 3'h1;
                        if (st_reg.cnt == `I2CSR_BIT_LAST) begin
                            st_next.ack_drv = 1'b0;
                            if (st_reg.state == i2csr_pkg::I2CSR_ADDR) begin
                                if (addr_match(shin[7:1], st_reg.addr_sel))
                                begin
                                    st_next.state = i2csr_pkg::I2CSR_ACK_ADDR;
                                    st_next.rw = shin[0];
                                end else begin
                                    st_next.state = i2csr_pkg::I2CSR_IGNORE;
                                end
                            end else if (st_reg.state == i2csr_pkg::I2CSR_REG)
                            begin
                                st_next.idx = shin;
                                st_next.state = i2csr_pkg::I2CSR_ACK_REG;
                            end else begin
                                st_next.wdata = shin;
                                st_next.wr = 1'b1;
                                st_next.state = i2csr_pkg::I2CSR_ACK_W;
                            end
                        end
                    end
                end
                i2csr_pkg::I2CSR_ACK_ADDR,
                i2csr_pkg::I2CSR_ACK_REG,
                i2csr_pkg::I2CSR_ACK_W: begin
                    if (line.scl_fall && !st_reg.ack_drv) begin
                        st_next.ack_drv = 1'b1;
                        st_next.oe = 1'b1;
                    end else if (line.scl_fall) begin
                        st_next.ack_drv = 1'b0;
                        st_next.oe = 1'b0;
                        st_next.cnt = `I2CSR_BIT_FIRST;
                        if (st_reg.state == i2csr_pkg::I2CSR_ACK_ADDR &&
                            st_reg.rw == `I2CSR_DIR_READ) begin
                            st_next.sh = reg_rdata_in;
                            st_next.oe = ~reg_rdata_in[`I2CSR_BYTE_MSB];
                            st_next.state = i2csr_pkg::I2CSR_RDATA;
                        end else if (st_reg.state ==
                                     i2csr_pkg::I2CSR_ACK_ADDR) begin
                            st_next.state = i2csr_pkg::I2CSR_REG;
                        end else begin
                            st_next.state = i2csr_pkg::I2CSR_WDATA;
                        end
                    end
                end
                i2csr_pkg::I2CSR_RDATA: begin
                    if (line.scl_fall) begin
                        if (st_reg.cnt == `I2CSR_BIT_LAST) begin
                            st_next.oe = 1'b0;
                            st_next.state = i2csr_pkg::I2CSR_RACK;
                        end else begin
                            st_next.cnt = st_reg.cnt + 3'h1;
                            st_next.sh = {st_reg.sh[6:0], 1'b0};
                            st_next.oe = ~st_reg.sh[`I2CSR_BYTE_MSB - 1];
                        end
                    end
                end
                i2csr_pkg::I2CSR_RACK: begin
                    if (line.scl_rise) begin
                        st_next.nack = line.sda;
                    end else if (line.scl_fall) begin
                        // A refused byte ends the read; the slave then
                        // keeps off the bus until the next condition.
                        if (st_reg.nack) begin
                            st_next.state = i2csr_pkg::I2CSR_IGNORE;
                        end else begin
                            st_next.cnt = `I2CSR_BIT_FIRST;
                            st_next.sh = reg_rdata_in;
                            st_next.oe = ~reg_rdata_in[`I2CSR_BYTE_MSB];
                            st_next.state = i2csr_pkg::I2CSR_RDATA;
                        end
                    end
                end
                i2csr_pkg::I2CSR_IGNORE: begin
                    st_next.oe = 1'b0;
                end
                default: begin
                    st_next.state = i2csr_pkg::I2CSR_IDLE;
                    st_next.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sda_out = st_reg.sdo;
    assign sda_oe_out = st_reg.oe;
    assign reg_index_out = st_reg.idx;
    assign reg_wdata_out = st_reg.wdata;
    assign reg_wr_out = st_reg.wr;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_start_restart;
        line.start && !line.stop |=>
            st_reg.state == i2csr_pkg::I2CSR_ADDR &&
            st_reg.cnt == `I2CSR_BIT_FIRST && !sda_oe_out;
    endproperty
    a_start_restart: assert property (p_start_restart)
        else $error("START did not restart address reception");

    property p_stop_free;
        line.stop |=> st_reg.state == i2csr_pkg::I2CSR_IDLE && !sda_oe_out;
    endproperty
    a_stop_free: assert property (p_stop_free)
        else $error("STOP did not free the bus");

    property p_ignore_released;
        st_reg.state == i2csr_pkg::I2CSR_IGNORE |-> !sda_oe_out;
    endproperty
    a_ignore_released: assert property (p_ignore_released)
        else $error("data driven after address mismatch");

    property p_addr_match;
        st_reg.state == i2csr_pkg::I2CSR_ADDR && line.scl_rise &&
        st_reg.cnt == `I2CSR_BIT_LAST && !line.start && !line.stop
        |=> (st_reg.state == i2csr_pkg::I2CSR_ACK_ADDR) ==
            addr_match($past(shin[7:1]), $past(st_reg.addr_sel));
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("address decision disagrees with strap");

    property p_index_capture;
        st_reg.state == i2csr_pkg::I2CSR_REG && line.scl_rise &&
        st_reg.cnt == `I2CSR_BIT_LAST && !line.start && !line.stop
        |=> reg_index_out == $past(shin);
    endproperty
    a_index_capture: assert property (p_index_capture)
        else $error("register index not captured");

    property p_write_store;
        st_reg.state == i2csr_pkg::I2CSR_WDATA && line.scl_rise &&
        !line.start && !line.stop
        |=> reg_wr_out == ($past(st_reg.cnt) == `I2CSR_BIT_LAST) ##1
            !reg_wr_out;
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("write strobe not on eighth bit");

    property p_ack_drive;
        st_reg.state == i2csr_pkg::I2CSR_ACK_W && line.scl_fall &&
        !st_reg.ack_drv && !line.stop && !line.start
        |=> sda_oe_out ##1 sda_oe_out[*2];
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("acknowledge not driven low");

    property p_oe_on_low_clock;
        $changed(sda_oe_out) && !$past(line.start) && !$past(line.stop)
        |-> !line.scl;
    endproperty
    a_oe_on_low_clock: assert property (p_oe_on_low_clock)
        else $error("data changed while clock high");

    property p_read_first_bit;
        $rose(st_reg.state == i2csr_pkg::I2CSR_RDATA)
        |-> sda_oe_out == !$past(reg_rdata_in[`I2CSR_BYTE_MSB]);
    endproperty
    a_read_first_bit: assert property (p_read_first_bit)
        else $error("read byte MSB not driven first");

    property p_master_ack_released;
        st_reg.state == i2csr_pkg::I2CSR_RACK |-> !sda_oe_out;
    endproperty
    a_master_ack_released: assert property (p_master_ack_released)
        else $error("data not released during master acknowledge");

endmodule

// *** hdl/i2csr_sync.sv ***
// Line sampler: brings clock, data and strap pins into the system clock
// domain through two flip-flops each and derives edges and bus conditions.
// Assumes the pins are asynchronous to sys_clk_in and far slower than it.
`timescale 1ns/1ps
`include "i2csr_params.svh"
module i2csr_sync (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic strap_in,
    i2csr_line_if.sampler line
);

    i2csr_pkg::i2csr_sync_t st_reg;
    i2csr_pkg::i2csr_sync_t st_next;

    // Idle bus levels are high, so the chain resets high to avoid a
    // false START right after reset.
    always_comb begin
        st_next = st_reg;
        st_next.scl_m = scl_in;
        st_next.scl_s = st_reg.scl_m;
        st_next.scl_d = st_reg.scl_s;
        st_next.sda_m = sda_in;
        st_next.sda_s = st_reg.sda_m;
        st_next.sda_d = st_reg.sda_s;
        st_next.strap_m = strap_in;
        st_next.strap_s = st_reg.strap_m;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign line.scl = st_reg.scl_s;
    assign line.sda = st_reg.sda_s;
    assign line.strap = st_reg.strap_s;
    assign line.scl_rise = st_reg.scl_s & ~st_reg.scl_d;
    assign line.scl_fall = ~st_reg.scl_s & st_reg.scl_d;
    assign line.start = st_reg.scl_s & st_reg.scl_d & st_reg.sda_d
                        & ~st_reg.sda_s;
    assign line.stop = st_reg.scl_s & st_reg.scl_d & ~st_reg.sda_d
                       & st_reg.sda_s;

endmodule

// *** tb/i2c_slave_register_access_test.sv ***
// Self-checking bench for the serial register access slave.
// Assumes the design files and the master model are compiled first.
`timescale 1ns/1ps
module i2c_slave_register_access_test;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic scl;
    logic pull;
    logic sda_line;
    logic sda_out;
    logic sda_oe_out;
    logic addr_sel = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] reg_index;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic [7:0] regs [256];
    logic [7:0] exp_regs [256];
    logic [15:0] got_wr [$];
    logic [15:0] exp_wr [$];
    logic [7:0] idx;
    logic [6:0] adr;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_cyc = 0;
    int seed = 91886;

    always #4 sys_clk_in = ~sys_clk_in;
    // The pull-up wins wherever nobody pulls the data line low.
    assign sda_line = !(pull || (sda_oe_out && !sda_out));
    assign reg_rdata = regs[reg_index];

    i2csr_slave u_i2csr_slave (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .addr_sel_in(addr_sel),
        .reg_rdata_in(reg_rdata),
        .reg_index_out(reg_index),
        .reg_wdata_out(reg_wdata),
        .reg_wr_out(reg_wr)
    );
    i2csr_master u_i2csr_master (
        .sys_clk_in(sys_clk_in),
        .sda_in(sda_line),
        .scl_out(scl),
        .sda_pull_out(pull)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Register file stand-in; also cuts a hung run short.
    always @(posedge sys_clk_in) begin
        n_cyc++;
        if (reg_wr === 1'b1) begin
            regs[reg_index] <= reg_wdata;
            got_wr.push_back({reg_index, reg_wdata});
        end
        if (n_cyc == 60000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // output changes only while clock low
    always @(sda_oe_out) begin
        if (rst_n_in === 1'b1) chk1(scl, 1'b0);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_writes();
        logic [15:0] g;
        logic [15:0] e;
        chk8(8'(got_wr.size()), 8'(exp_wr.size()));
        while (got_wr.size() > 0 && exp_wr.size() > 0) begin
            g = got_wr.pop_front();
            e = exp_wr.pop_front();
            chk8(g[15:8], e[15:8]);
            chk8(g[7:0], e[7:0]);
        end
        got_wr.delete();
        exp_wr.delete();
    endtask

    task automatic send(input logic [7:0] d, input logic exp_n);
        logic ack_n;
        u_i2csr_master.write_byte(d, ack_n);
        chk1(ack_n, exp_n);
    endtask

    task automatic do_write(input logic [6:0] a, input logic [7:0] ix,
                            input int nd, input logic hit);
        logic [7:0] d;
        u_i2csr_master.start_cond();
        send({a, 1'b0}, !hit);
        send(ix, !hit);
        for (int i = 0; i < nd; i++) begin
            d = 8'($random(seed));
            send(d, !hit);
            if (hit) begin
                exp_wr.push_back({ix, d});
                exp_regs[ix] = d;
            end
        end
        u_i2csr_master.stop_cond();
        check_writes();
    endtask

    // index write, repeated start, then read bytes
    task automatic do_read(input logic [6:0] a, input logic [7:0] ix,
                           input int nr);
        logic [7:0] d;
        logic line;
        u_i2csr_master.start_cond();
        send({a, 1'b0}, 1'b0);
        send(ix, 1'b0);
        u_i2csr_master.start_cond();
        send({a, 1'b1}, 1'b0);
        for (int i = 0; i < nr; i++) begin
            u_i2csr_master.read_byte(1'(i == nr - 1), d, line);
            chk8(d, exp_regs[ix]);
            chk1(line, 1'(i == nr - 1));
        end
        u_i2csr_master.stop_cond();
        check_writes();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5a;
            exp_regs[i] = 8'(i) ^ 8'h5a;
        end
        repeat (16) @(negedge sys_clk_in);
        chk1(sda_oe_out, 1'b0);
        rst_n_in = 1'b1;
        repeat (8) @(negedge sys_clk_in);
        // both strap levels, own and other address
        for (int s = 0; s < 2; s++) begin
            addr_sel = 1'(s);
            repeat (8) @(negedge sys_clk_in);
            idx = 8'($random(seed));
            do_write(7'h20 + 7'(s), idx, 2, 1'b1);
            do_write(7'h21 - 7'(s), idx, 1, 1'b0);
            do_read(7'h20 + 7'(s), idx, 2);
        end
        adr = 7'h21;
        for (int k = 0; k < 6; k++) begin
            idx = 8'($random(seed));
            do_write(adr, idx, 1 + ($random(seed) & 3), 1'b1);
            do_read(adr, idx, 1 + ($random(seed) & 1));
        end
        // repeated start after the index restarts the transfer
        u_i2csr_master.start_cond();
        send({adr, 1'b0}, 1'b0);
        send(~idx, 1'b0);
        do_write(adr, idx, 1, 1'b1);
        do_read(adr, ~idx, 1);
        do_read(adr, idx, 1);
        stop_test();
    end
endmodule

// *** tb/i2csr_master.sv ***
// Bus master model: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module i2csr_master (
    input wire logic sys_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    // Half of the 80 ns bus clock period, in system clock cycles.
    localparam int HALF = 5;

    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    task automatic clock_bit(input logic b, output logic seen);
        wait_cyc(2);
        sda_pull_out = ~b;
        wait_cyc(HALF - 2);
        scl_out = 1'b1;
        wait_cyc(HALF);
        seen = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic start_cond();
        wait_cyc(HALF);
        sda_pull_out = 1'b0;
        wait_cyc(HALF);
        scl_out = 1'b1;
        wait_cyc(HALF);
        sda_pull_out = 1'b1;
        wait_cyc(HALF);
        scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        wait_cyc(2);
        sda_pull_out = 1'b1;
        wait_cyc(HALF - 2);
        scl_out = 1'b1;
        wait_cyc(HALF);
        sda_pull_out = 1'b0;
        wait_cyc(2 * HALF);
    endtask

    // MSB first, line released for the acknowledge
    task automatic write_byte(input logic [7:0] d, output logic ack_n);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], seen);
        end
        clock_bit(1'b1, ack_n);
    endtask

    // master acknowledges every byte but the last one read
    task automatic read_byte(input logic last, output logic [7:0] d,
                             output logic line);
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(last, line);
    endtask
endmodule
